/* common/ish_cfg.svh */
// Functional notes
// R1 - Address hold: release low, irq
// R2 - Start: status, irq if enabled
// R3 - Show ack phase, direction, kind
// R4 - Held ack sends software value
// R5 - Read address: release low, irq
// R6 - Load only after address ack
// R7 - Ninth pulse ack captured
// R8 - Controller nack frees bus
// R9 - High match: update, ack, irq
// R10 - Reading byte clears full; code clears it only when the read empties the receive FIFO
// R11 - Own address locked in ack
// R12 - Own address write frees clock
// R13 - Low mismatch: flags, release kept
// R14 - Update flag stretches clock
// R15 - Data bytes acked, flagged
// R16 - Holds same in ten-bit mode
// R17 - Read ack clears release
// R18 - Stretch enable holds after ack
// R19 - Data hold: release low
// R20 - Pull clock only once low
// R21 - Hold until release, line free
// R22 - Irq sticky until cleared
// R23 - Hardware clear beats write
`ifndef ISH_CFG_SVH
`define ISH_CFG_SVH
`define ISH_DATA_W      8
`define ISH_FIFO_DEPTH  16
`define ISH_PTR_W       4
`define ISH_CNT_W       4
`define ISH_CNT_ZERO    4'h0
`define ISH_CNT_LAST    4'h8
`define ISH_CNT_ACK     4'h9
`define ISH_BYTE_RST    8'h00
`define ISH_RW_BIT      0
`define ISH_MSB_IDX     3'h7
`endif

/* common/ish_pkg.sv */
package ish_pkg;
    typedef enum logic [2:0] {
        ISH_IDLE     = 3'b000,
        ISH_ADDR     = 3'b001,
        ISH_ADDR_LOW = 3'b010,
        ISH_RX       = 3'b011,
        ISH_TX       = 3'b100
    } ish_state_type;
    typedef logic [7:0] ish_byte_type;
endpackage

/* common/ish_stream_if.sv */
`timescale 1ns/10ps
interface ish_stream_if;
    ish_pkg::ish_byte_type data;
    logic                  valid;
    logic                  ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

/* design/ish_fifo.sv */
`timescale 1ns/10ps
`include "ish_cfg.svh"
module ish_fifo #(
    parameter int WIDTH = `ISH_DATA_W,
    parameter int DEPTH = `ISH_FIFO_DEPTH,
    parameter int PTR_W = `ISH_PTR_W
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    ish_stream_if.snk             in_if,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0]   count_q;
    logic             push;
    logic             pop;

    assign in_if.ready = (count_q != (PTR_W+1)'(DEPTH));
    assign out_valid   = (count_q != '0);
    assign out_data    = mem_q[rd_ptr_q];
    assign push        = in_if.valid & in_if.ready;
    assign pop         = out_valid & out_ready;

    always_ff @(posedge core_clk) begin
        if (clk_en && push) begin
            mem_q[wr_ptr_q] <= in_if.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_q <= PTR_W'(wr_ptr_q + 1'b1);
            end
            if (pop) begin
                rd_ptr_q <= PTR_W'(rd_ptr_q + 1'b1);
            end
            if (push && !pop) begin
                count_q <= (PTR_W+1)'(count_q + 1'b1);
            end else if (pop && !push) begin
                count_q <= (PTR_W+1)'(count_q - 1'b1);
            end
        end
    end
endmodule // ish_fifo

/* design/ish_slave.sv */
`timescale 1ns/10ps
`include "ish_cfg.svh"
module ish_slave (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        ten_bit_mode,
    input  wire logic        address_hold_enable,
    input  wire logic        data_hold_enable,
    input  wire logic        stretch_enable,
    input  wire logic        start_irq_enable,
    input  wire logic        ack_value_to_send,
    input  wire logic        release_wr,
    input  wire logic        release_wr_value,
    input  wire logic        irq_clear,
    input  wire logic        own_address_wr,
    input  wire logic [7:0]  own_address_wr_data,
    input  wire logic        tx_valid,
    input  wire logic [7:0]  tx_data,
    output logic             tx_ready,
    output logic             rx_valid,
    output logic [7:0]       rx_data,
    input  wire logic        rx_ready,
    output logic [7:0]       own_address_register,
    output logic             clock_release_bit,
    output logic             port_irq_flag,
    output logic             start_seen,
    output logic             stop_seen,
    output logic             ack_phase_indicator,
    output logic             read_write_bit,
    output logic             data_not_address,
    output logic             buffer_full_flag,
    output logic             received_ack_value,
    output logic             update_address_flag
);
    ish_stream_if push_if ();

    ish_pkg::ish_state_type state_q;
    ish_pkg::ish_state_type next_state_q;
    logic [`ISH_CNT_W-1:0]  cnt_q;
    ish_pkg::ish_byte_type  shift_q;
    ish_pkg::ish_byte_type  tx_shift_q;
    ish_pkg::ish_byte_type  push_data_q;
    logic scl_meta_q, scl_s_q, scl_d_q;
    logic sda_meta_q, sda_s_q, sda_d_q;
    logic ack_auto_q, ack_sw_q, tx_full_q, push_pend_q, holding_q, sda_oe_q;
    logic scl_rise, scl_fall, start_det, stop_det;
    logic byte_end, ack_end, matched, ack_low, ack_ok;
    logic addr_phase, hold_point, ack_stretch, addr_accept, hold_req;

    function automatic logic addr_match(input ish_pkg::ish_byte_type rcv,
                                        input ish_pkg::ish_byte_type own,
                                        input logic                  full);
        addr_match = full ? (rcv == own) : (rcv[7:1] == own[7:1]);
    endfunction

    // Pin synchronisers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scl_meta_q <= 1'b1;
            scl_s_q    <= 1'b1;
            scl_d_q    <= 1'b1;
            sda_meta_q <= 1'b1;
            sda_s_q    <= 1'b1;
            sda_d_q    <= 1'b1;
        end else if (clk_en) begin
            scl_meta_q <= scl_in;
            scl_s_q    <= scl_meta_q;
            scl_d_q    <= scl_s_q;
            sda_meta_q <= sda_in;
            sda_s_q    <= sda_meta_q;
            sda_d_q    <= sda_s_q;
        end
    end

    assign scl_rise   = scl_s_q & ~scl_d_q;
    assign scl_fall   = ~scl_s_q & scl_d_q;
    assign start_det  = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
    assign stop_det   = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;
    assign byte_end   = scl_fall && (cnt_q == `ISH_CNT_LAST) && (state_q != ish_pkg::ISH_IDLE);
    assign ack_end    = scl_fall && (cnt_q == `ISH_CNT_ACK);
    assign addr_phase = (state_q == ish_pkg::ISH_ADDR) || (state_q == ish_pkg::ISH_ADDR_LOW);
    assign matched    = addr_match(shift_q, own_address_register,
                                   state_q == ish_pkg::ISH_ADDR_LOW);
    assign ack_low    = ack_sw_q ? ~ack_value_to_send : ack_auto_q; // [R4]
    assign ack_ok     = (state_q == ish_pkg::ISH_TX) ? ~received_ack_value : sda_oe_q;
    // Hold points
    assign hold_point = byte_end && ((addr_phase && matched && address_hold_enable) // [R1] [R16]
                        || (state_q == ish_pkg::ISH_RX && data_hold_enable));  // [R19]
    // Ack stretch
    assign ack_stretch = ack_end && ack_ok && (stretch_enable                  // [R18]
                        || (state_q == ish_pkg::ISH_ADDR && read_write_bit)    // [R5] [R17]
                        || state_q == ish_pkg::ISH_TX);
    assign addr_accept = own_address_wr && !ack_phase_indicator;               // [R11]
    assign hold_req    = ~clock_release_bit | push_pend_q
                         | (update_address_flag & ~ack_phase_indicator); // [R14]

    // Transfer state
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q      <= ish_pkg::ISH_IDLE;
            next_state_q <= ish_pkg::ISH_IDLE;
            cnt_q        <= `ISH_CNT_ZERO;
        end else if (clk_en) begin
            if (start_det) begin
                state_q <= ish_pkg::ISH_ADDR;
                cnt_q   <= `ISH_CNT_ZERO;
            end else if (stop_det) begin
                state_q <= ish_pkg::ISH_IDLE;
                cnt_q   <= `ISH_CNT_ZERO;
            end else if (scl_rise && state_q != ish_pkg::ISH_IDLE) begin
                cnt_q <= `ISH_CNT_W'(cnt_q + 1'b1);
            end else if (ack_end) begin
                cnt_q <= `ISH_CNT_ZERO;
                if (!ack_ok) begin
                    state_q <= ish_pkg::ISH_IDLE; // [R8]
                end else begin
                    state_q <= next_state_q;
                end
            end
            if (byte_end) begin
                case (state_q)
                    ish_pkg::ISH_ADDR: begin
                        if (shift_q[`ISH_RW_BIT]) begin
                            next_state_q <= ish_pkg::ISH_TX;
                        end else if (ten_bit_mode) begin
                            next_state_q <= ish_pkg::ISH_ADDR_LOW;
                        end else begin
                            next_state_q <= ish_pkg::ISH_RX;
                        end
                    end
                    ish_pkg::ISH_ADDR_LOW: next_state_q <= ish_pkg::ISH_RX;
                    ish_pkg::ISH_RX:       next_state_q <= ish_pkg::ISH_RX;
                    ish_pkg::ISH_TX:       next_state_q <= ish_pkg::ISH_TX;
                    default:               next_state_q <= ish_pkg::ISH_IDLE;
                endcase
            end
        end
    end

    // Receive shifter
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            shift_q <= `ISH_BYTE_RST;
        end else if (clk_en && scl_rise && cnt_q < `ISH_CNT_LAST
                     && state_q != ish_pkg::ISH_IDLE) begin
            shift_q <= {shift_q[6:0], sda_s_q};
        end
    end

    // Ack slot
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ack_auto_q          <= 1'b0;
            ack_sw_q            <= 1'b0;
            ack_phase_indicator <= 1'b0;
        end else if (clk_en) begin
            if (start_det || stop_det || ack_end) begin
                ack_phase_indicator <= 1'b0;
                ack_sw_q            <= 1'b0;
                ack_auto_q          <= 1'b0;
            end else if (byte_end && state_q != ish_pkg::ISH_TX) begin
                ack_phase_indicator <= 1'b1; // [R3]
                ack_sw_q            <= hold_point;
                ack_auto_q          <= addr_phase ? matched : 1'b1; // [R9] [R15]
            end
        end
    end

    // Direction status
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            read_write_bit   <= 1'b0;
            data_not_address <= 1'b0;
        end else if (clk_en) begin
            if (start_det) begin
                data_not_address <= 1'b0;
            end else if (byte_end && addr_phase && matched) begin
                data_not_address <= 1'b0; // [R3]
                if (state_q == ish_pkg::ISH_ADDR) begin
                    read_write_bit <= shift_q[`ISH_RW_BIT];
                end
            end else if (byte_end && state_q != ish_pkg::ISH_ADDR_LOW) begin
                data_not_address <= 1'b1; // [R3]
            end
        end
    end

    // Data line drive
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sda_oe_q <= 1'b0;
        end else if (clk_en) begin
            if (start_det || stop_det || state_q == ish_pkg::ISH_IDLE) begin
                sda_oe_q <= 1'b0;
            end else if (ack_phase_indicator) begin
                sda_oe_q <= ack_low; // [R4] [R15]
            end else if (state_q == ish_pkg::ISH_TX && cnt_q < `ISH_CNT_LAST && !scl_s_q) begin
                sda_oe_q <= ~tx_shift_q[3'(`ISH_MSB_IDX - cnt_q[2:0])];
            end else if (!scl_s_q) begin
                sda_oe_q <= 1'b0; // [R8]
            end
        end
    end

    // Ack capture
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            received_ack_value <= 1'b0;
        end else if (clk_en && scl_rise && state_q == ish_pkg::ISH_TX
                     && cnt_q == `ISH_CNT_LAST) begin
            received_ack_value <= sda_s_q; // [R7]
        end
    end

    // Release bit
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clock_release_bit <= 1'b1;
        end else if (clk_en) begin
            if (hold_point || ack_stretch) begin
                clock_release_bit <= 1'b0; // [R23] [R1] [R19] [R5] [R17] [R18]
            end else if (release_wr) begin
                clock_release_bit <= release_wr_value;
            end
        end
    end

    // Sticky interrupt flag
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            port_irq_flag <= 1'b0;
        end else if (clk_en) begin
            if ((start_det && start_irq_enable)                           // [R2]
                || hold_point                                             // [R1] [R19]
                || (ack_end && (ack_ok || state_q == ish_pkg::ISH_TX      // [R5] [R15]
                    || state_q == ish_pkg::ISH_ADDR_LOW))) begin          // [R13]
                port_irq_flag <= 1'b1;
            end else if (irq_clear) begin
                port_irq_flag <= 1'b0; // [R22]
            end
        end
    end

    // Start and stop status
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b0;
        end else if (clk_en) begin
            if (start_det) begin
                start_seen <= 1'b1; // [R2]
                stop_seen  <= 1'b0;
            end else if (stop_det) begin
                start_seen <= 1'b0;
                stop_seen  <= 1'b1;
            end
        end
    end

    // Update flag, own address
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            update_address_flag  <= 1'b0;
            own_address_register <= `ISH_BYTE_RST;
        end else if (clk_en) begin
            if (addr_accept) begin
                own_address_register <= own_address_wr_data; // [R11]
            end
            if (byte_end && ((state_q == ish_pkg::ISH_ADDR && matched && ten_bit_mode
                              && !shift_q[`ISH_RW_BIT])                    // [R9]
                             || state_q == ish_pkg::ISH_ADDR_LOW)) begin   // [R13]
                update_address_flag <= 1'b1;
            end else if (addr_accept) begin
                update_address_flag <= 1'b0; // [R12]
            end
        end
    end

    // Receive hand-off
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            push_pend_q <= 1'b0;
            push_data_q <= `ISH_BYTE_RST;
        end else if (clk_en) begin
            if (byte_end && ((addr_phase && matched)                       // [R13]
                             || state_q == ish_pkg::ISH_RX)) begin
                push_pend_q <= 1'b1;
                push_data_q <= shift_q;
            end else if (push_if.ready) begin
                push_pend_q <= 1'b0;
            end
        end
    end

    assign push_if.valid = push_pend_q;
    assign push_if.data  = push_data_q;

    ish_fifo #(
        .WIDTH (`ISH_DATA_W),
        .DEPTH (`ISH_FIFO_DEPTH),
        .PTR_W (`ISH_PTR_W)
    ) u_rx_fifo (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .in_if     (push_if),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready) // [R10]
    );

    // Transmit buffer
    assign tx_ready = (state_q == ish_pkg::ISH_TX) && (cnt_q == `ISH_CNT_ZERO)
                      && !tx_full_q && !scl_s_q; // [R6]

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tx_full_q  <= 1'b0;
            tx_shift_q <= `ISH_BYTE_RST;
        end else if (clk_en) begin
            if (start_det || stop_det) begin
                tx_full_q <= 1'b0;
            end else if (tx_valid && tx_ready) begin
                tx_full_q  <= 1'b1; // [R6]
                tx_shift_q <= tx_data;
            end else if (scl_rise && state_q == ish_pkg::ISH_TX
                         && cnt_q == `ISH_CNT_ZERO) begin
                tx_full_q <= 1'b0;
            end
        end
    end

    assign buffer_full_flag = rx_valid | tx_full_q; // [R10]

    // Clock hold
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            holding_q <= 1'b0;
        end else if (clk_en) begin
            if (!hold_req) begin
                holding_q <= 1'b0; // [R21]
            end else if (!scl_s_q) begin
                holding_q <= 1'b1; // [R20] [R14]
            end
        end
    end

    assign scl_out = 1'b0;
    assign scl_oe  = holding_q;
    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_q;
endmodule // ish_slave

/* verif/i2c_slave_hold_and_stretch_test.sv */
`timescale 1ns/10ps
module i2c_slave_hold_and_stretch_test;
    logic       core_clk, sys_rst, clk_en, ten_bit_mode, address_hold_enable;
    logic       data_hold_enable, stretch_enable, start_irq_enable, ack_value_to_send;
    logic       release_wr, release_wr_value, irq_clear, own_address_wr, tx_valid;
    logic       rx_ready, scl_out, scl_oe, sda_out, sda_oe, tx_ready, rx_valid;
    logic       clock_release_bit, port_irq_flag, start_seen, stop_seen, read_write_bit;
    logic       ack_phase_indicator, data_not_address, buffer_full_flag;
    logic       received_ack_value, update_address_flag, scl_rel, sda_rel, stuck, a;
    logic [7:0] own_address_wr_data, tx_data, rx_data, own_address_register, b;
    wire        scl_in = scl_rel & ~scl_oe;
    wire        sda_in = sda_rel & ~sda_oe;
    int         failures = 0, cmp_count = 0, cyc = 0;

    ish_slave u_ish_slave (.*);
    ish_ctrl_model u_ctl (.*);

    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        $display("cmp %0d fail %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic mid();
        @(negedge core_clk);
    endtask
    task automatic clr_irq();
        @(posedge core_clk) irq_clear <= 1'h1;
        @(posedge core_clk) irq_clear <= 1'h0;
    endtask
    task automatic rel();
        @(posedge core_clk) release_wr <= 1'h1;
        @(posedge core_clk) release_wr <= 1'h0;
    endtask
    task automatic wr_own(input logic [7:0] v);
        @(posedge core_clk) own_address_wr <= 1'h1;
        own_address_wr_data <= v;
        @(posedge core_clk) own_address_wr <= 1'h0;
        tick(2);
    endtask
    task automatic pop(input logic [7:0] v);
        @(posedge core_clk) rx_ready <= 1'h1;
        mid();
        check("rxv", rx_valid, 1'h1);
        check("rxd", rx_data, v);
        @(posedge core_clk) rx_ready <= 1'h0;
        tick(1);
    endtask
    task automatic load_tx(input logic [7:0] v);
        int n;
        n = 0;
        @(posedge core_clk) tx_data <= v;
        tx_valid <= 1'h1;
        mid();
        while (tx_ready !== 1'h1 && n < 100) begin
            mid();
            n++;
        end
        check("txr", tx_ready, 1'h1);
        @(posedge core_clk) tx_valid <= 1'h0;
        mid();
        check("bf", buffer_full_flag, 1'h1);
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000 || stuck === 1'h1) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        {sys_rst, clk_en, release_wr_value, rx_ready} = 4'hE;
        {ten_bit_mode, address_hold_enable, data_hold_enable, stretch_enable} = 4'h0;
        {start_irq_enable, ack_value_to_send, release_wr, irq_clear} = 4'h0;
        {own_address_wr, tx_valid, own_address_wr_data, tx_data} = 18'h00000;
        tick(10);
        sys_rst <= 1'h0;
        tick(4);
        {start_irq_enable, address_hold_enable, data_hold_enable} <= 3'h7;
        wr_own(8'hA4);
        u_ctl.start_c();
        mid();
        check("start", start_seen, 1'h1);
        check("sirq", port_irq_flag, 1'h1);
        clr_irq();
        mid();
        check("irq", port_irq_flag, 1'h0);
        check("txr", tx_ready, 1'h0);
        u_ctl.put_byte(8'hA4);
        mid();
        check("rel", clock_release_bit, 1'h0);
        check("irq", port_irq_flag, 1'h1);
        check("ackt", ack_phase_indicator, 1'h1);
        check("rw", read_write_bit, 1'h0);
        check("da", data_not_address, 1'h0);
        check("scl", scl_oe, 1'h1);
        wr_own(8'h11);
        mid();
        check("own", own_address_register, 8'hA4);
        pop(8'hA4);
        mid();
        check("bf", buffer_full_flag, 1'h0);
        clr_irq();
        rel();
        u_ctl.pulse(1'h1, a);
        check("ack", a, 1'h0);
        for (int i = 0; i < 2; i++) begin
            ack_value_to_send <= i[0];
            u_ctl.put_byte(8'h3C + 8'(i));
            mid();
            check("rel", clock_release_bit, 1'h0);
            check("da", data_not_address, 1'h1);
            pop(8'h3C + 8'(i));
            clr_irq();
            rel();
            u_ctl.pulse(1'h1, a);
            mid();
            check("ack", a, i[0]);
            check("irq", port_irq_flag, i == 0);
        end
        u_ctl.stop_c();
        mid();
        check("stop", stop_seen, 1'h1);
        {address_hold_enable, data_hold_enable, ack_value_to_send} <= 3'h0;
        u_ctl.start_c();
        clr_irq();
        u_ctl.put_byte(8'hA5);
        u_ctl.pulse(1'h1, a);
        mid();
        check("ack", a, 1'h0);
        check("rel", clock_release_bit, 1'h0);
        check("irq", port_irq_flag, 1'h1);
        check("rw", read_write_bit, 1'h1);
        pop(8'hA5);
        for (int i = 0; i < 2; i++) begin
            clr_irq();
            load_tx(i ? 8'h81 : 8'hC3);
            rel();
            u_ctl.get_byte(b);
            u_ctl.pulse(i[0], a);
            mid();
            check("txd", b, i ? 8'h81 : 8'hC3);
            check("rack", received_ack_value, i[0]);
            check("rel", clock_release_bit, i[0]);
            check("scl", scl_oe, !i[0]);
            check("irq", port_irq_flag, 1'h1);
        end
        u_ctl.stop_c();
        ten_bit_mode <= 1'h1;
        for (int i = 0; i < 2; i++) begin
            wr_own(8'hF2);
            u_ctl.start_c();
            u_ctl.put_byte(8'hF2);
            u_ctl.pulse(1'h1, a);
            mid();
            check("ack", a, 1'h0);
            check("ua", update_address_flag, 1'h1);
            check("irq", port_irq_flag, 1'h1);
            check("scl", scl_oe, 1'h1);
            check("rel", clock_release_bit, 1'h1);
            pop(8'hF2);
            clr_irq();
            wr_own(8'h37);
            mid();
            check("scl", scl_oe, 1'h0);
            u_ctl.put_byte(i ? 8'h37 : 8'h55);
            u_ctl.pulse(1'h1, a);
            mid();
            check("ack", a, i == 0);
            check("ua", update_address_flag, 1'h1);
            check("irq", port_irq_flag, 1'h1);
            check("rel", clock_release_bit, 1'h1);
            check("bf", buffer_full_flag, i[0]);
            if (i == 1)
                pop(8'h37);
            clr_irq();
            wr_own(8'hF2);
            if (i == 1) begin
                stretch_enable <= 1'h1;
                u_ctl.put_byte(8'h5A);
                u_ctl.pulse(1'h1, a);
                mid();
                check("ack", a, 1'h0);
                check("rel", clock_release_bit, 1'h0);
                check("scl", scl_oe, 1'h1);
                pop(8'h5A);
                rel();
            end
            u_ctl.stop_c();
        end
        report_and_stop();
    end
endmodule // i2c_slave_hold_and_stretch_test

/* verif/ish_ctrl_model.sv */
`timescale 1ns/10ps
module ish_ctrl_model (
    input  wire logic core_clk,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_rel,
    output logic      sda_rel,
    output logic      stuck
);
    initial begin
        scl_rel = 1'h1;
        sda_rel = 1'h1;
        stuck   = 1'h0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic pulse(input logic b_out, output logic b_in);
        int n;
        n = 0;
        wt(1);
        sda_rel <= b_out;
        wt(10);
        scl_rel <= 1'h1;
        wt(1);
        while (scl_in !== 1'h1 && n < 4000) begin
            n++;
            wt(1);
        end
        if (n >= 4000)
            stuck <= 1'h1;
        wt(10);
        b_in = sda_in;
        wt(10);
        scl_rel <= 1'h0;
        wt(10);
    endtask
    task automatic start_c();
        wt(1);
        sda_rel <= 1'h0;
        wt(10);
        scl_rel <= 1'h0;
        wt(10);
    endtask
    task automatic stop_c();
        wt(1);
        sda_rel <= 1'h0;
        wt(10);
        scl_rel <= 1'h1;
        wt(10);
        sda_rel <= 1'h1;
        wt(20);
    endtask
    task automatic put_byte(input logic [7:0] d);
        logic x;
        for (int i = 7; i >= 0; i--) pulse(d[i], x);
    endtask
    task automatic get_byte(output logic [7:0] d);
        for (int i = 7; i >= 0; i--) pulse(1'h1, d[i]);
    endtask
endmodule // ish_ctrl_model

/* verif/ish_slave_properties.sv */
`timescale 1ns/10ps
module ish_slave_props (
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic       scl_in,
    input wire logic       scl_oe,
    input wire logic       irq_clear,
    input wire logic       release_wr,
    input wire logic       own_address_wr,
    input wire logic [7:0] own_address_wr_data,
    input wire logic [7:0] own_address_register,
    input wire logic       start_irq_enable,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       clock_release_bit,
    input wire logic       port_irq_flag,
    input wire logic       start_seen,
    input wire logic       ack_phase_indicator,
    input wire logic       read_write_bit,
    input wire logic       buffer_full_flag,
    input wire logic       update_address_flag
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    irq_sticky_a: assert property (port_irq_flag && !irq_clear |=> port_irq_flag)
        else $error("irq dropped");
    release_set_a: assert property ($rose(clock_release_bit) |-> $past(release_wr))
        else $error("bad release");
    late_pull_a: assert property ($rose(scl_oe) |-> !$past(scl_in, 3))
        else $error("early pull");
    hold_kept_a: assert property (scl_oe && !clock_release_bit |=> scl_oe)
        else $error("hold lost");
    own_locked_a: assert property (ack_phase_indicator && own_address_wr
        |=> $stable(own_address_register)) else $error("own changed");
    own_write_a: assert property (own_address_wr && !ack_phase_indicator
        |=> own_address_register == $past(own_address_wr_data)) else $error("own lost");
    start_irq_a: assert property ($rose(start_seen) |-> port_irq_flag || !start_irq_enable)
        else $error("start irq");
    hold_irq_a: assert property ($fell(clock_release_bit) && !$past(release_wr)
        |-> port_irq_flag) else $error("hold irq");
    tx_load_a: assert property (tx_valid && tx_ready |=> buffer_full_flag)
        else $error("load no full");
    tx_window_a: assert property (tx_ready |-> read_write_bit && !ack_phase_indicator)
        else $error("early load");
    ua_release_a: assert property (own_address_wr && update_address_flag && clock_release_bit
        && !ack_phase_indicator |-> ##[1:3] !scl_oe) else $error("ua held");
endmodule // ish_slave_props

bind ish_slave ish_slave_props u_ish_slave_props (.*);
